// ### power_modes_pkg.sv
// Purpose: Constants for the core power-mode sequencer
// Assumes: 10 MHz pclk, 32-bit APB register access
// Notes:   Offsets are byte addresses
package power_modes_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0]  pwr_ctrl_offset   = 8'h00;
  localparam logic [7:0]  pwr_status_offset = 8'h04;
  localparam logic [7:0]  wdt_ctrl_offset   = 8'h08;
  localparam logic [7:0]  mon_ctrl_offset   = 8'h0c;
  // ==========================================================================
  // Field positions
  localparam int          idle_bit          = 0;
  localparam int          stop_bit          = 1;
  localparam int          wdt_en_bit        = 0;
  localparam int          wdt_kick_bit      = 1;
  localparam int          mon_en_bit        = 0;
  localparam logic [31:0] pwr_ctrl_reset    = 32'h0000_0000;
  localparam logic [31:0] wdt_ctrl_reset    = 32'h0000_0001;
  localparam logic [31:0] mon_ctrl_reset    = 32'h0000_0000;
  localparam logic [15:0] reset_vector      = 16'h0000;
  // ==========================================================================
  // Timing
  localparam int          clk_mhz           = 10;
  localparam int          mon_timeout_us    = 100;
  localparam int          mon_timeout_cyc   = mon_timeout_us * clk_mhz;
  localparam int          wdt_width         = 21;
  localparam int          reset_hold_cyc    = 12;
  // ==========================================================================
  // States
  typedef enum logic [3:0] {
    st_run   = 4'b0001,
    st_idle  = 4'b0010,
    st_stop  = 4'b0100,
    st_reset = 4'b1000
  } pwr_state_t;
endpackage

// ### core_idle_stop_power_modes.sv
// Purpose: Idle and stop power-mode control for an 8051-style core
// Assumes: Instruction retire strobe and interrupt request from the core
// Notes:   Registers over APB; stop wake is reset only
`timescale 1ns/1ps
// Summary of operation
// - Setting the idle bit halts the CPU once the setting instruction retires.
// - While idle all registers and memory keep their contents.
// - While idle the clocks and peripherals keep running and only the CPU halts.
// - An enabled interrupt while idle clears the idle bit and resumes the CPU.
// - After idle wake the interrupt is serviced and then execution continues after the idle write.
// - A reset ending idle or stop runs the reset sequence and fetches from 0x0000.
// - An enabled watchdog keeps counting in idle and its reset ends idle.
// - A single-byte follower with an interrupt in the write phase may lose later wakes.
// - Setting the stop bit stops CPU and oscillator once the instruction retires.
// - In stop all interrupts and timers are off except the lost-clock monitor.
// - Stop ends only on an internal or external reset.
// - An enabled lost-clock monitor resets the device after 100 us in stop.
module core_idle_stop_power_modes #(
  parameter int mon_timeout = power_modes_pkg::mon_timeout_cyc,
  parameter int wdt_width   = power_modes_pkg::wdt_width
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        instr_retire,
  input  wire logic        instr_single_byte,
  input  wire logic        irq_enabled_pending,
  input  wire logic        ext_reset_req,
  output logic             cpu_halt,
  output logic             osc_stop,
  output logic             periph_clk_en,
  output logic             irq_service,
  output logic             core_reset,
  output logic [15:0]      fetch_addr
);
  // ==========================================================================
  // Bus decode
  wire logic        acc        = psel & penable;
  wire logic        wr         = acc & pwrite;
  wire logic        hit_ctrl   = paddr == power_modes_pkg::pwr_ctrl_offset;
  wire logic        hit_stat   = paddr == power_modes_pkg::pwr_status_offset;
  wire logic        hit_wdt    = paddr == power_modes_pkg::wdt_ctrl_offset;
  wire logic        hit_mon    = paddr == power_modes_pkg::mon_ctrl_offset;
  wire logic        hit_any    = hit_ctrl | hit_stat | hit_wdt | hit_mon;

  logic [1:0]                  mode_req;
  logic                        wdt_en;
  logic                        mon_en;
  logic                        wake_broken;
  logic [wdt_width-1:0]        wdt_cnt;
  logic [15:0]                 mon_cnt;
  logic [3:0]                  hold_cnt;
  logic                        last_reset_wdt;
  logic                        last_reset_mon;
  power_modes_pkg::pwr_state_t state;
  power_modes_pkg::pwr_state_t next_state;

  // ==========================================================================
  // Mode and wake decode
  wire logic wr_ctrl  = wr & hit_ctrl;
  wire logic wr_mon   = wr & hit_mon;
  wire logic wr_wdt   = wr & hit_wdt;
  wire logic in_idle  = state == power_modes_pkg::st_idle;
  wire logic in_stop  = state == power_modes_pkg::st_stop;
  wire logic in_run   = state == power_modes_pkg::st_run;
  wire logic wdt_kick = wr_wdt & pwdata[power_modes_pkg::wdt_kick_bit];
  // Watchdog counts in run and idle, never in stop
  wire logic wdt_fire = wdt_en & ~in_stop & (&wdt_cnt);
  wire logic mon_fire = mon_en & in_stop &
                        (mon_cnt == 16'(mon_timeout - 1));
  wire logic any_rst  = ext_reset_req | wdt_fire | mon_fire;
  // Mode taken only when the setting instruction retires
  wire logic go_idle  = in_run & instr_retire & mode_req[power_modes_pkg::idle_bit];
  wire logic go_stop  = in_run & instr_retire & mode_req[power_modes_pkg::stop_bit];
  // Interrupt landing during the idle write with a one-byte follower
  wire logic hazard   = go_idle & instr_single_byte & irq_enabled_pending;
  wire logic wake_irq = in_idle & irq_enabled_pending & ~wake_broken;
  wire logic hold_done = hold_cnt == 4'(power_modes_pkg::reset_hold_cyc - 1);

  // ==========================================================================
  // Reset sequencing
  wire logic in_reset  = state == power_modes_pkg::st_reset;
  wire logic exit_rst  = hold_done & ~ext_reset_req;
  wire logic hold_run  = in_reset & ~hold_done;
  wire logic set_cause = any_rst & ~in_reset;
  wire logic wdt_clr   = in_reset | wdt_kick | ~wdt_en | in_stop;
  wire logic mon_run   = in_stop & mon_en;

  // ==========================================================================
  // Next state
  always_comb begin
    next_state = state;
    unique case (state)
      power_modes_pkg::st_run: begin
        if (any_rst) begin
          next_state = power_modes_pkg::st_reset;
        end else if (go_stop) begin
          next_state = power_modes_pkg::st_stop;
        end else if (go_idle) begin
          next_state = power_modes_pkg::st_idle;
        end
      end
      power_modes_pkg::st_idle: begin
        if (any_rst) begin
          next_state = power_modes_pkg::st_reset;
        end else if (wake_irq) begin
          next_state = power_modes_pkg::st_run;
        end
      end
      power_modes_pkg::st_stop: begin
        if (any_rst) begin
          next_state = power_modes_pkg::st_reset;
        end
      end
      power_modes_pkg::st_reset: begin
        if (exit_rst) begin
          next_state = power_modes_pkg::st_run;
        end
      end
      default: next_state = power_modes_pkg::st_reset;
    endcase
  end

  // ==========================================================================
  // State and control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= power_modes_pkg::st_reset;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Mode request register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_req <= power_modes_pkg::pwr_ctrl_reset[1:0];
    end else if (state == power_modes_pkg::st_reset) begin
      mode_req <= power_modes_pkg::pwr_ctrl_reset[1:0];
    end else if (wake_irq) begin
      mode_req[power_modes_pkg::idle_bit] <= 1'b0;
    end else if (wr_ctrl & in_run) begin
      mode_req <= pwdata[1:0];
    end
  end

  // ==========================================================================
  // Wake hazard latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_broken <= 1'b0;
    end else if (state == power_modes_pkg::st_reset) begin
      wake_broken <= 1'b0;
    end else if (hazard) begin
      wake_broken <= 1'b1;
    end
  end

  // ==========================================================================
  // Watchdog and monitor enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_en <= power_modes_pkg::wdt_ctrl_reset[power_modes_pkg::wdt_en_bit];
    end else if (in_reset) begin
      wdt_en <= power_modes_pkg::wdt_ctrl_reset[power_modes_pkg::wdt_en_bit];
    end else if (wr_wdt) begin
      wdt_en <= pwdata[power_modes_pkg::wdt_en_bit];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_en <= power_modes_pkg::mon_ctrl_reset[power_modes_pkg::mon_en_bit];
    end else if (in_reset) begin
      mon_en <= power_modes_pkg::mon_ctrl_reset[power_modes_pkg::mon_en_bit];
    end else if (wr_mon) begin
      mon_en <= pwdata[power_modes_pkg::mon_en_bit];
    end
  end

  // ==========================================================================
  // Watchdog counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_cnt <= '0;
    end else if (wdt_clr) begin
      wdt_cnt <= '0;
    end else begin
      wdt_cnt <= wdt_cnt + 1'b1;
    end
  end

  // ==========================================================================
  // Monitor counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_cnt <= 16'h0000;
    end else if (mon_run) begin
      mon_cnt <= mon_cnt + 16'h0001;
    end else begin
      mon_cnt <= 16'h0000;
    end
  end

  // ==========================================================================
  // Reset hold counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt <= 4'h0;
    end else if (hold_run) begin
      hold_cnt <= hold_cnt + 4'h1;
    end else if (~in_reset) begin
      hold_cnt <= 4'h0;
    end
  end

  // ==========================================================================
  // Cause of last reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reset_wdt <= 1'b0;
    end else if (set_cause) begin
      last_reset_wdt <= wdt_fire;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reset_mon <= 1'b0;
    end else if (set_cause) begin
      last_reset_mon <= mon_fire;
    end
  end

  // ==========================================================================
  // Outputs
  wire logic next_halt  = next_state != power_modes_pkg::st_run;
  wire logic next_osc   = next_state == power_modes_pkg::st_stop;
  // Peripherals stay clocked in idle, off only in stop
  wire logic next_pclk  = next_state != power_modes_pkg::st_stop;
  wire logic next_rst   = next_state == power_modes_pkg::st_reset;
  wire logic next_svc   = wake_irq & ~any_rst;

  // ==========================================================================
  // Status and read data
  wire logic [31:0] rd_ctrl = {30'h0, mode_req};
  wire logic [31:0] rd_wdt  = {31'h0, wdt_en};
  wire logic [31:0] rd_mon  = {31'h0, mon_en};
  wire logic [31:0] rd_stat = {26'h0, last_reset_mon, last_reset_wdt, wake_broken,
                               in_stop, in_idle, in_run};
  wire logic [31:0] rd_mux  = hit_ctrl ? rd_ctrl :
                              hit_stat ? rd_stat :
                              hit_wdt  ? rd_wdt :
                              hit_mon  ? rd_mon : 32'h0000_0000;
  wire logic        setup      = psel & ~penable;
  wire logic        next_err   = setup & ~hit_any;
  wire logic [31:0] next_rdata = (setup & ~pwrite) ? rd_mux : 32'h0000_0000;

  // ==========================================================================
  // Core controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_halt <= 1'b1;
    end else begin
      cpu_halt <= next_halt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_stop <= 1'b0;
    end else begin
      osc_stop <= next_osc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_clk_en <= 1'b1;
    end else begin
      periph_clk_en <= next_pclk;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_service <= 1'b0;
    end else begin
      irq_service <= next_svc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset <= 1'b1;
    end else begin
      core_reset <= next_rst;
    end
  end

  // ==========================================================================
  // Reset vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_addr <= power_modes_pkg::reset_vector;
    end else if (next_rst) begin
      fetch_addr <= power_modes_pkg::reset_vector;
    end
  end

  // ==========================================================================
  // Bus response
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= next_err;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_rdata;
    end
  end
endmodule

// ### pwr_modes_chk.sv
// Purpose: Port checker for the core power-mode sequencer
// Assumes: Single pclk domain, presetn async active low
// Notes:   Bound to the top module below
`timescale 1ns/1ps
module pwr_modes_chk #(
  parameter int mon_timeout = power_modes_pkg::mon_timeout_cyc,
  parameter int wdt_width   = power_modes_pkg::wdt_width
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        irq_enabled_pending,
  input wire logic        ext_reset_req,
  input wire logic        cpu_halt,
  input wire logic        osc_stop,
  input wire logic        periph_clk_en,
  input wire logic        irq_service,
  input wire logic        core_reset,
  input wire logic [15:0] fetch_addr
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_STOP_HALT: assert property (osc_stop |-> ##[0:1] cpu_halt)
    else $error("stop without cpu halt");
  AST_PERIPH_CLK: assert property (periph_clk_en != osc_stop)
    else $error("peripheral clock wrong for mode");
  AST_STOP_NO_IRQ: assert property (osc_stop && irq_enabled_pending |=> !irq_service)
    else $error("interrupt served in stop");
  AST_WAKE_RUN: assert property (irq_service |-> ##[0:2] !cpu_halt)
    else $error("cpu not resumed after wake");
  AST_WAKE_PULSE: assert property (irq_service |=> !irq_service)
    else $error("service pulse too long");
  AST_RESET_FETCH: assert property (core_reset |-> fetch_addr == 16'h0000 && cpu_halt)
    else $error("reset fetch address wrong");
  AST_STOP_EXIT: assert property ($fell(osc_stop) |-> ##[0:1] core_reset)
    else $error("stop left without reset");
  AST_EXT_RESET: assert property (ext_reset_req |-> ##[0:2] core_reset)
    else $error("external reset ignored");
  cover property (irq_service);
  cover property ($fell(osc_stop));
  cover property ($rose(cpu_halt) && !osc_stop);
endmodule

bind core_idle_stop_power_modes pwr_modes_chk #(
  .mon_timeout(mon_timeout), .wdt_width(wdt_width)
) i_chk (
  .pclk(pclk), .presetn(presetn), .irq_enabled_pending(irq_enabled_pending),
  .ext_reset_req(ext_reset_req), .cpu_halt(cpu_halt), .osc_stop(osc_stop),
  .periph_clk_en(periph_clk_en), .irq_service(irq_service),
  .core_reset(core_reset), .fetch_addr(fetch_addr)
);

// ### core_idle_stop_power_modes_bench.sv
// Purpose: Self-checking bench for the core power-mode sequencer
// Assumes: Short monitor and watchdog counts via parameters
// Notes:   Seeded random delays and unmapped addresses
`timescale 1ns/1ps
module core_idle_stop_power_modes_bench;
  localparam int mon = 20;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        instr_retire, instr_single_byte, irq_enabled_pending, ext_reset_req;
  logic        cpu_halt, osc_stop, periph_clk_en, irq_service, core_reset;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] fetch_addr;
  logic [5:0]  o;
  int          errors, n_checks, cyc, n, i;
  assign o = {core_reset, !core_reset, osc_stop, cpu_halt, irq_service, !cpu_halt};
  core_idle_stop_power_modes #(.mon_timeout(mon), .wdt_width(6)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr_retire(instr_retire),
    .instr_single_byte(instr_single_byte), .irq_enabled_pending(irq_enabled_pending),
    .ext_reset_req(ext_reset_req), .cpu_halt(cpu_halt), .osc_stop(osc_stop),
    .periph_clk_en(periph_clk_en), .irq_service(irq_service),
    .core_reset(core_reset), .fetch_addr(fetch_addr));
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  // ==========================================================================
  // Tasks
  task automatic summarize();
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      errors++;
      $display("BAD %0t no pready", $time);
    end
    q = prdata; e = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  function automatic logic [31:0] exp_stat(input int st, input logic brk, input logic wdr,
                                           input logic mnr);
    exp_stat = {26'h0, mnr, wdr, brk, 3'(1 << st)};
  endfunction
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic wait_on(input int b, input int lim);
    n = 0;
    while (o[b] !== 1'b1 && n < lim) begin @(posedge pclk); n++; end
    chk({31'h0, o[b]}, 32'h1);
  endtask
  task automatic retire(input logic sb, input logic irq);
    instr_retire <= 1; instr_single_byte <= sb; irq_enabled_pending <= irq;
    @(posedge pclk);
    instr_retire <= 0; instr_single_byte <= 0;
  endtask
  task automatic recover();
    chk({16'h0, fetch_addr}, 32'h0);
    wait_on(4, 40);
    apb(1, 8'h08, 32'h0);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin errors++; summarize(); end
  end
  // ==========================================================================
  // Scenarios
  initial begin
    {psel, penable, pwrite, paddr, pwdata, instr_retire} = '0;
    {instr_single_byte, irq_enabled_pending, ext_reset_req} = '0;
    presetn = 0;
    void'($urandom(23));
    repeat (10) @(posedge pclk);
    presetn <= 1;
    wait_on(4, 40);
    rd(8'h08, 32'h1);
    apb(1, 8'h08, 32'h0);
    rd(8'h00, 32'h0); rd(8'h0c, 32'h0); rd(8'h04, exp_stat(0, 0, 0, 0));
    apb(1, {6'($urandom_range(4, 63)), 2'b00}, $urandom);
    chk({31'h0, e}, 32'h1);
    for (i = 0; i < 3; i++) begin
      apb(1, 8'h00, 32'h1);
      retire(0, 0);
      wait_on(2, 5);
      rd(8'h04, exp_stat(1, 0, 0, 0));
      rd(8'h00, 32'h1);
      chk({30'h0, osc_stop, periph_clk_en}, 32'h1);
      repeat ($urandom_range(1, 30)) @(posedge pclk);
      irq_enabled_pending <= 1;
      wait_on(1, 5);
      irq_enabled_pending <= 0;
      wait_on(0, 5);
      rd(8'h00, 32'h0);
    end
    apb(1, 8'h00, 32'h1);
    retire(1, 1);
    repeat (10) @(posedge pclk);
    rd(8'h04, exp_stat(1, 1, 0, 0));
    irq_enabled_pending <= 0; ext_reset_req <= 1;
    wait_on(5, 5);
    ext_reset_req <= 0;
    recover();
    rd(8'h04, exp_stat(0, 0, 0, 0));
    apb(1, 8'h0c, 32'h1); apb(1, 8'h00, 32'h2);
    retire(0, 1);
    wait_on(3, 5);
    chk({30'h0, osc_stop, periph_clk_en}, 32'h2);
    wait_on(5, mon + 10);
    chk({31'h0, n >= mon - 3}, 32'h1);
    irq_enabled_pending <= 0;
    recover();
    rd(8'h04, exp_stat(0, 0, 0, 1)); rd(8'h0c, 32'h0);
    apb(1, 8'h00, 32'h2);
    retire(0, 0);
    repeat (60) @(posedge pclk);
    chk({31'h0, osc_stop}, 32'h1);
    ext_reset_req <= 1;
    wait_on(5, 5);
    ext_reset_req <= 0;
    recover();
    rd(8'h00, 32'h0);
    apb(1, 8'h08, 32'h1); apb(1, 8'h00, 32'h1);
    retire(0, 0);
    wait_on(2, 5);
    wait_on(5, 80);
    recover();
    rd(8'h04, exp_stat(0, 0, 1, 0));
    summarize();
  end
endmodule
